// [core/temp_status_pkg.sv]
package temp_status_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h02;
  localparam logic [7:0] IDX_CONFIG = 8'h03;
  localparam logic [7:0] IDX_RATE = 8'h04;
  localparam logic [7:0] IDX_INT_HIGH = 8'h05;
  localparam logic [7:0] IDX_INT_LOW = 8'h06;
  localparam logic [7:0] IDX_EXT_HIGH = 8'h07;
  localparam logic [7:0] IDX_EXT_LOW = 8'h08;
  localparam logic [7:0] IDX_CONFIG_MIRROR = 8'h09;
  localparam logic [7:0] IDX_RATE_MIRROR = 8'h0a;
  localparam logic [7:0] IDX_INT_HIGH_MIRROR = 8'h0b;
  localparam logic [7:0] IDX_INT_LOW_MIRROR = 8'h0c;
  localparam logic [7:0] IDX_EXT_HIGH_MIRROR = 8'h0d;
  localparam logic [7:0] IDX_EXT_LOW_MIRROR = 8'h0e;
  localparam logic [7:0] IDX_ONE_SHOT = 8'h0f;

  // status bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_INT_HIGH = 6;
  localparam int ST_INT_LOW = 5;
  localparam int ST_EXT_HIGH = 4;
  localparam int ST_EXT_LOW = 3;
  localparam int ST_FAULT = 2;
  localparam int ST_EXT_CRIT = 1;
  localparam int ST_INT_CRIT = 0;

  // configuration bit positions and writable mask
  localparam int CFG_EVENT_UNMASK = 7;
  localparam int CFG_STANDBY = 6;
  localparam int CFG_COMPARATOR = 5;
  localparam int CFG_REC_DIS = 4;
  localparam int CFG_RANGE_EXT = 2;
  localparam int CFG_AVG_DIS = 1;
  localparam logic [7:0] CFG_WR_MASK = 8'hf6;

  // reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [3:0] RST_RATE = 4'h6;
  localparam logic [7:0] RST_HIGH_LIMIT = 8'h55;
  localparam logic [7:0] RST_LOW_LIMIT = 8'h00;

  // rate codes: doubling up to the last defined code, else one per second
  localparam logic [3:0] RATE_CODE_MAX = 4'ha;
  localparam logic [3:0] RATE_CODE_FALLBACK = 4'h4;

  // slowest conversion period and the clock
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SLOWEST_PERIOD_S = 16;
  localparam int unsigned SLOWEST_PERIOD_CYCLES =
    SLOWEST_PERIOD_S * (1000000000 / CLK_PERIOD_NS);

  typedef enum logic {
    CONV_IDLE = 1'b0,
    CONV_RUN = 1'b1
  } conv_state_t;

  // result handed back by the converter at the end of a conversion
  typedef struct packed {
    logic valid;
    logic [7:0] int_temp;
    logic [7:0] ext_temp;
    logic diode_fault;
    logic int_crit;
    logic ext_crit;
  } conv_result_t;

  // live option outputs towards the analog front end
  typedef struct packed {
    logic range_extended;
    logic series_resistance_correction;
    logic dynamic_averaging_disable;
    logic [3:0] rate_code;
  } front_cfg_t;

endpackage

// [core/temp_status_cfg.sv]
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - status register resets zero, read clears latched event flags
// - busy bit shows conversion, never drives pins
// - internal over-high flag drives event pin
// - internal under-low flag drives event pin
// - external high and low flags drive event
// - diode fault flag drives event pin
// - critical flags drive critical pin, self-clear
// - flags latch until read, comparator follows live
// - pins wait for consecutive count reached
// - configuration reachable at both addresses
// - event unmask bit gates pin outside comparator
// - standby bit stops continuous conversion
// - comparator mode ignores event unmask bit
// - bit four disables series resistance correction
// - bit two selects extended offset-binary range
// - bit one disables dynamic averaging
// - rate register holds four-bit code, default six
// - codes zero to ten double the rate
// - undefined codes give one per second
// - mirrored limits share one storage
// - standby limits apply at next conversion
// - one-shot in idle standby starts conversion
// - consecutive counters count repeats, reset otherwise
module temp_status_cfg
  import temp_status_pkg::*;
#(
  parameter int unsigned RATE_BASE_CYCLES = SLOWEST_PERIOD_CYCLES,
  parameter int CNT_W = 4,
  parameter logic [3:0] CONSEC_COUNT = 4'h1
) (
  input wire logic CLK_I, // 100 MHz clock
  input wire logic SYS_RST_I, // synchronous reset, active high
  input wire logic CE_I, // clock enable, freezes state when low
  input wire logic PSEL_I, // apb select
  input wire logic PENABLE_I, // apb access phase
  input wire logic PWRITE_I, // apb direction
  input wire logic [11:0] PADDR_I, // apb byte address
  input wire logic [31:0] PWDATA_I, // apb write data
  output logic [31:0] PRDATA_O, // apb read data
  output logic PREADY_O, // apb ready
  output logic PSLVERR_O, // apb error on unmapped address
  input wire conv_result_t RESULT_I, // converter result, valid one cycle
  output logic CONV_START_O, // one-cycle conversion start
  output front_cfg_t FRONT_CFG_O, // options for the front end
  output logic EVENT_O, // event pin, active high
  output logic CRIT_O // critical pin, active high
);

  logic [7:0] flags_reg;
  logic [7:0] config_reg;
  logic [3:0] rate_reg;
  logic [7:0] limit_reg [4];
  logic [7:0] limit_used_reg [4];
  logic [31:0] timer_reg;
  logic [CNT_W-1:0] int_cnt_reg;
  logic [CNT_W-1:0] ext_cnt_reg;
  conv_state_t state_reg;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic start_reg;
  logic event_reg;
  logic crit_reg;
  front_cfg_t front_reg;

  // apb decode; upper address bits must be zero to hit a register
  logic [7:0] idx;
  logic in_range;
  logic access;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic [1:0] lim_sel;
  logic lim_hit;
  logic [7:0] rd_value;
  assign idx = PADDR_I[9:2];
  assign in_range = (PADDR_I[11:10] == 2'h0) && (PADDR_I[1:0] == 2'h0);
  assign access = PSEL_I && PENABLE_I;
  assign wr_done = access && pready_reg && PWRITE_I && mapped;
  assign rd_done = access && pready_reg && !PWRITE_I && mapped;

  // limit index folding, mirrors land on the same entry
  always_comb begin
    lim_hit = 1'b0;
    lim_sel = 2'h0;
    if (idx >= IDX_INT_HIGH && idx <= IDX_EXT_LOW) begin
      lim_hit = 1'b1;
      lim_sel = 2'(idx - IDX_INT_HIGH);
    end else if (idx >= IDX_INT_HIGH_MIRROR && idx <= IDX_EXT_LOW_MIRROR) begin
      lim_hit = 1'b1;
      lim_sel = 2'(idx - IDX_INT_HIGH_MIRROR);
    end
  end

  // read mux; reserved bits read zero
  always_comb begin
    mapped = in_range;
    rd_value = 8'h00;
    if (lim_hit) begin
      rd_value = limit_reg[lim_sel];
    end else begin
      unique case (idx)
        IDX_STATUS: rd_value = flags_reg;
        IDX_CONFIG, IDX_CONFIG_MIRROR: rd_value = config_reg & CFG_WR_MASK;
        IDX_RATE, IDX_RATE_MIRROR: rd_value = {4'h0, rate_reg};
        IDX_ONE_SHOT: rd_value = 8'h00;
        default: mapped = 1'b0;
      endcase
    end
  end

  // one wait state so read data leaves a flop
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (CE_I) begin
      if (access && !pready_reg) begin
        pready_reg <= 1'b1;
        prdata_reg <= {24'h00_0000, rd_value};
        pslverr_reg <= !mapped;
      end else begin
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
      end
    end
  end

  // configuration and rate storage
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      config_reg <= RST_CONFIG;
      rate_reg <= RST_RATE;
    end else if (CE_I && wr_done) begin
      if (idx == IDX_CONFIG || idx == IDX_CONFIG_MIRROR) begin
        config_reg <= PWDATA_I[7:0] & CFG_WR_MASK;
      end
      if (idx == IDX_RATE || idx == IDX_RATE_MIRROR) begin
        rate_reg <= PWDATA_I[3:0];
      end
    end
  end

  // limits written by software; host keeps them in the active format
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      limit_reg[0] <= RST_HIGH_LIMIT;
      limit_reg[1] <= RST_LOW_LIMIT;
      limit_reg[2] <= RST_HIGH_LIMIT;
      limit_reg[3] <= RST_LOW_LIMIT;
    end else if (CE_I && wr_done && lim_hit) begin
      limit_reg[lim_sel] <= PWDATA_I[7:0];
    end
  end

  // conversion period from the rate code
  logic [3:0] eff_code;
  logic [31:0] period;
  assign eff_code = (rate_reg > RATE_CODE_MAX) ? RATE_CODE_FALLBACK : rate_reg;
  assign period = RATE_BASE_CYCLES >> eff_code;

  // start sources: timer in active mode, one-shot, leaving standby
  logic standby;
  logic oneshot_hit;
  logic leave_standby;
  logic start_now;
  assign standby = config_reg[CFG_STANDBY];
  assign oneshot_hit = wr_done && idx == IDX_ONE_SHOT && standby && state_reg == CONV_IDLE;
  assign leave_standby = wr_done && standby && !PWDATA_I[CFG_STANDBY] &&
    (idx == IDX_CONFIG || idx == IDX_CONFIG_MIRROR);
  assign start_now = (state_reg == CONV_IDLE) &&
    (oneshot_hit || (!standby && timer_reg == 32'h0000_0000));

  // conversion sequencer; the timer restarts with every conversion
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_reg <= CONV_IDLE;
      timer_reg <= 32'h0000_0000;
      start_reg <= 1'b0;
    end else if (CE_I) begin
      start_reg <= start_now;
      if (start_now) begin
        state_reg <= CONV_RUN;
        timer_reg <= period - 32'h0000_0001;
      end else begin
        if (state_reg == CONV_RUN && RESULT_I.valid) begin
          state_reg <= CONV_IDLE;
        end
        if (leave_standby) begin
          timer_reg <= 32'h0000_0000;
        end else if (!standby && timer_reg != 32'h0000_0000) begin
          timer_reg <= timer_reg - 32'h0000_0001;
        end
      end
    end
  end

  // limits frozen at conversion start, so standby edits wait
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      limit_used_reg[0] <= RST_HIGH_LIMIT;
      limit_used_reg[1] <= RST_LOW_LIMIT;
      limit_used_reg[2] <= RST_HIGH_LIMIT;
      limit_used_reg[3] <= RST_LOW_LIMIT;
    end else if (CE_I && start_now) begin
      limit_used_reg <= limit_reg;
    end
  end

  // live conditions; unsigned compare works for both formats
  logic res_ok;
  logic int_high;
  logic int_low;
  logic ext_high;
  logic ext_low;
  logic int_cond;
  logic ext_cond;
  logic [CNT_W-1:0] int_cnt_next;
  logic [CNT_W-1:0] ext_cnt_next;
  logic int_qual;
  logic ext_qual;
  assign res_ok = RESULT_I.valid && state_reg == CONV_RUN;
  assign int_high = RESULT_I.int_temp > limit_used_reg[0];
  assign int_low = RESULT_I.int_temp <= limit_used_reg[1];
  assign ext_high = RESULT_I.ext_temp > limit_used_reg[2];
  assign ext_low = RESULT_I.ext_temp <= limit_used_reg[3];
  assign int_cond = int_high || int_low || RESULT_I.int_crit;
  assign ext_cond = ext_high || ext_low || RESULT_I.diode_fault || RESULT_I.ext_crit;
  assign int_cnt_next = !int_cond ? '0 : (&int_cnt_reg ? int_cnt_reg : int_cnt_reg + 1'b1);
  assign ext_cnt_next = !ext_cond ? '0 : (&ext_cnt_reg ? ext_cnt_reg : ext_cnt_reg + 1'b1);
  assign int_qual = int_cnt_next >= CNT_W'(CONSEC_COUNT);
  assign ext_qual = ext_cnt_next >= CNT_W'(CONSEC_COUNT);

  // consecutive counters per channel, updated once per result
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      int_cnt_reg <= '0;
      ext_cnt_reg <= '0;
    end else if (CE_I && res_ok) begin
      int_cnt_reg <= int_cnt_next;
      ext_cnt_reg <= ext_cnt_next;
    end
  end

  // flag update; only bits actually returned by a read are cleared
  logic comparator;
  logic [4:0] live_flags;
  logic [4:0] clr_mask;
  assign comparator = config_reg[CFG_COMPARATOR];
  assign live_flags = {int_high && int_qual, int_low && int_qual, ext_high && ext_qual,
                       ext_low && ext_qual, RESULT_I.diode_fault && ext_qual};
  assign clr_mask = (rd_done && idx == IDX_STATUS) ? prdata_reg[6:2] : 5'h00;
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      flags_reg <= RST_STATUS;
    end else if (CE_I) begin
      flags_reg[ST_BUSY] <= start_now || (state_reg == CONV_RUN && !RESULT_I.valid);
      if (comparator) begin
        if (res_ok) begin
          flags_reg[6:2] <= live_flags;
        end
      end else begin
        flags_reg[6:2] <= (flags_reg[6:2] & ~clr_mask) | (res_ok ? live_flags : 5'h00);
      end
      if (res_ok) begin
        if (!RESULT_I.int_crit && !RESULT_I.ext_crit) begin
          flags_reg[1:0] <= 2'h0;
        end else begin
          flags_reg[ST_EXT_CRIT] <= flags_reg[ST_EXT_CRIT] || (RESULT_I.ext_crit && ext_qual);
          flags_reg[ST_INT_CRIT] <= flags_reg[ST_INT_CRIT] || (RESULT_I.int_crit && int_qual);
        end
      end
    end
  end

  // pins follow the flags one cycle later; busy is never included
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      event_reg <= 1'b0;
      crit_reg <= 1'b0;
    end else if (CE_I) begin
      event_reg <= (|flags_reg[6:2]) && (comparator || config_reg[CFG_EVENT_UNMASK]);
      crit_reg <= |flags_reg[1:0];
    end
  end

  // front end options as registered copies of the configuration
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      front_reg <= '0;
    end else if (CE_I) begin
      front_reg.range_extended <= config_reg[CFG_RANGE_EXT];
      front_reg.series_resistance_correction <= !config_reg[CFG_REC_DIS];
      front_reg.dynamic_averaging_disable <= config_reg[CFG_AVG_DIS];
      front_reg.rate_code <= eff_code;
    end
  end
  assign PRDATA_O = prdata_reg;
  assign PREADY_O = pready_reg;
  assign PSLVERR_O = pslverr_reg;
  assign CONV_START_O = start_reg;
  assign FRONT_CFG_O = front_reg;
  assign EVENT_O = event_reg;
  assign CRIT_O = crit_reg;
  // checks on the block's own behaviour
  property p_busy_no_pin;
    @(posedge CLK_I) disable iff (SYS_RST_I || !CE_I)
    $past(flags_reg[6:2] == 5'h00) && $past(CE_I) |-> !EVENT_O;
  endproperty
  a_busy_no_pin: assert property (p_busy_no_pin) else $error("event pin without flag");
  property p_read_clear;
    @(posedge CLK_I) disable iff (SYS_RST_I || !CE_I)
    rd_done && idx == IDX_STATUS && !comparator && !res_ok |=>
      (flags_reg[6:2] & $past(prdata_reg[6:2])) == 5'h00;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status read did not clear");
  property p_cfg_mirror;
    @(posedge CLK_I) disable iff (SYS_RST_I || !CE_I)
    wr_done && idx == IDX_CONFIG_MIRROR |=> config_reg == ($past(PWDATA_I[7:0]) & CFG_WR_MASK);
  endproperty
  a_cfg_mirror: assert property (p_cfg_mirror) else $error("config mirror write lost");
  property p_rate_upper;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    PREADY_O && !PWRITE_I && (idx == IDX_RATE || idx == IDX_RATE_MIRROR) |->
      PRDATA_O[7:4] == 4'h0;
  endproperty
  a_rate_upper: assert property (p_rate_upper) else $error("rate upper bits not zero");
  property p_mask_holds;
    @(posedge CLK_I) disable iff (SYS_RST_I || !CE_I)
    $past(!comparator && !config_reg[CFG_EVENT_UNMASK]) && $past(CE_I) |-> !EVENT_O;
  endproperty
  a_mask_holds: assert property (p_mask_holds) else $error("masked event pin asserted");
  property p_comp_ignores_mask;
    @(posedge CLK_I) disable iff (SYS_RST_I || !CE_I)
    comparator && flags_reg[ST_INT_HIGH] |=> EVENT_O;
  endproperty
  a_comp_ignores_mask: assert property (p_comp_ignores_mask) else $error("comparator pin off");
  property p_standby_quiet;
    @(posedge CLK_I) disable iff (SYS_RST_I || !CE_I)
    standby && !oneshot_hit |=> !CONV_START_O;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet) else $error("start during standby");
  property p_oneshot;
    @(posedge CLK_I) disable iff (SYS_RST_I || !CE_I)
    oneshot_hit |=> CONV_START_O ##1 flags_reg[ST_BUSY];
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot did not start");
  property p_crit_pin;
    @(posedge CLK_I) disable iff (SYS_RST_I || !CE_I)
    flags_reg[1:0] != 2'h0 |=> CRIT_O;
  endproperty
  a_crit_pin: assert property (p_crit_pin) else $error("critical pin not driven");
  property p_consec;
    @(posedge CLK_I) disable iff (SYS_RST_I || !CE_I)
    res_ok && !int_cond |=> int_cnt_reg == '0;
  endproperty
  a_consec: assert property (p_consec) else $error("counter not reset");
  c_conversion: cover property (@(posedge CLK_I) CONV_START_O ##[1:20] res_ok);
  c_event: cover property (@(posedge CLK_I) !EVENT_O ##1 EVENT_O);
  c_crit_release: cover property (@(posedge CLK_I) CRIT_O ##1 !CRIT_O);
  c_oneshot: cover property (@(posedge CLK_I) oneshot_hit);
endmodule
`default_nettype wire

// [core/dummy_unused_never.sv]
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// [bench/conv_model.sv]
`timescale 1ns/1ns
`default_nettype none
module conv_model
  import temp_status_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire logic start_i, // conversion start pulse
  input wire logic [7:0] int_temp_i, // internal reading to return
  input wire logic [7:0] ext_temp_i, // external reading to return
  input wire logic fault_i, // diode fault to report
  input wire logic int_crit_i, // internal critical comparator
  input wire logic ext_crit_i, // external critical comparator
  input wire logic [7:0] delay_i, // countdown load; result comes one cycle after it runs out
  output var conv_result_t result_o // result, valid one cycle
);
  logic run_reg;
  logic [7:0] cnt_reg;

  // countdown from start; idle fields toggle so stale data never looks settled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg <= 1'b0;
      cnt_reg <= 8'h00;
      result_o <= '0;
    end else if (start_i) begin
      run_reg <= 1'b1;
      cnt_reg <= delay_i;
      result_o <= {1'b0, ~result_o[18:0]};
    end else if (run_reg && cnt_reg == 8'h00) begin
      run_reg <= 1'b0;
      result_o <= {1'b1, int_temp_i, ext_temp_i, fault_i, int_crit_i, ext_crit_i};
    end else begin
      cnt_reg <= cnt_reg - 8'h01;
      result_o <= {1'b0, ~result_o[18:0]};
    end
  end
endmodule
`default_nettype wire

// [bench/tb_temp_status_cfg.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_temp_status_cfg;
  import temp_status_pkg::*;
  logic CLK_I = 1'b0;
  logic SYS_RST_I = 1'b1;
  logic PSEL_I = 1'b0;
  logic PENABLE_I = 1'b0;
  logic PWRITE_I = 1'b0;
  logic [11:0] PADDR_I = 12'h000;
  logic [31:0] PWDATA_I = 32'h0;
  logic [31:0] PRDATA_O;
  logic PREADY_O, PSLVERR_O, CONV_START_O, EVENT_O, CRIT_O;
  conv_result_t RESULT_I;
  front_cfg_t FRONT_CFG_O;
  logic [7:0] it = 8'h30, et = 8'h30, dly = 8'h02;
  logic flt = 1'b0, ic = 1'b0, ec = 1'b0;
  int miscompares = 0, samples_checked = 0, n;
  logic [31:0] rd;
  logic er;
  logic [11:0] bad [4] = '{12'h040, 12'h004, 12'h00e, 12'h40c};
  // refused reads still carry whatever the index decodes to, config here
  logic [7:0] bd [4] = '{8'h00, 8'h00, 8'h40, 8'h40};
  logic [7:0] ti [5] = '{8'h60, 8'h00, 8'h30, 8'h30, 8'h30};
  logic [7:0] te [5] = '{8'h30, 8'h30, 8'h60, 8'h00, 8'h30};
  logic [7:0] ex [5] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04};
  logic [3:0] rc [3] = '{4'h4, 4'h5, 4'hf};
  int pe [3] = '{64, 32, 64};

  always #5 CLK_I = ~CLK_I;

  // shortened base period so the rate codes give short, exact intervals
  temp_status_cfg #(.RATE_BASE_CYCLES(1024), .CONSEC_COUNT(4'h2)) u_temp_status_cfg (
    .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(1'b1), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .RESULT_I(RESULT_I),
    .CONV_START_O(CONV_START_O), .FRONT_CFG_O(FRONT_CFG_O), .EVENT_O(EVENT_O),
    .CRIT_O(CRIT_O));

  conv_model u_conv_model (
    .clk_i(CLK_I), .rst_i(SYS_RST_I), .start_i(CONV_START_O), .int_temp_i(it),
    .ext_temp_i(et), .fault_i(flt), .int_crit_i(ic), .ext_crit_i(ec), .delay_i(dly),
    .result_o(RESULT_I));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask

  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  // one apb transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge CLK_I);
    PSEL_I <= 1'b1;
    PENABLE_I <= 1'b0;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= {24'h0, d};
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    do begin
      @(posedge CLK_I);
      k++;
    end while (PREADY_O !== 1'b1 && k < 20);
    chk1(PREADY_O, 1'b1);
    rd = PRDATA_O;
    er = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, ba(i), d);
  endtask

  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    xfer(1'b0, ba(i), 8'h00);
    chk(rd, {24'h0, e});
    chk1(er, 1'b0);
  endtask

  // one-shot conversion, then let flags and pins settle
  task automatic conv1();
    int k;
    k = 0;
    wr(IDX_ONE_SHOT, 8'h00);
    while (RESULT_I.valid !== 1'b1 && k < 200) begin
      @(posedge CLK_I);
      k++;
    end
    chk1(RESULT_I.valid, 1'b1);
    repeat (3) @(posedge CLK_I);
  endtask

  // interval between start pulses, after two pulses to settle a new code
  task automatic period(output int p);
    repeat (3) begin
      p = 0;
      do begin
        @(posedge CLK_I);
        p++;
      end while (CONV_START_O !== 1'b1 && p < 3000);
    end
  endtask

  // watchdog: the whole sequence needs well under ten thousand cycles
  initial begin
    #500000;
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    rdc(IDX_CONFIG, 8'h00);
    rdc(IDX_RATE, 8'h06);
    chk(32'(FRONT_CFG_O), 32'h26);
    wr(IDX_CONFIG, 8'h40);
    // let a conversion started before standby run out
    repeat (30) @(posedge CLK_I);
    rdc(IDX_STATUS, 8'h00);
    n = 0;
    repeat (300) begin
      @(posedge CLK_I);
      if (CONV_START_O === 1'b1) n++;
    end
    chk(n, 0);
    // unmapped, misaligned and high-bit addresses are refused, writes dropped
    foreach (bad[k]) begin
      xfer(1'b1, bad[k], 8'hff);
      chk1(er, 1'b1);
      xfer(1'b0, bad[k], 8'h00);
      chk({er, rd[30:0]}, {1'b1, 23'h0, bd[k]});
    end
    rdc(IDX_CONFIG, 8'h40);
    rdc(IDX_ONE_SHOT, 8'h00);
    wr(IDX_CONFIG_MIRROR, 8'hff);
    rdc(IDX_CONFIG, 8'hf6);
    chk(32'(FRONT_CFG_O), 32'h56);
    wr(IDX_CONFIG, 8'h40);
    rdc(IDX_CONFIG_MIRROR, 8'h40);
    chk(32'(FRONT_CFG_O), 32'h26);
    for (int c = 0; c < 16; c++) begin
      wr(c[0] ? IDX_RATE : IDX_RATE_MIRROR, 8'hf0 | 8'(c));
      rdc(c[0] ? IDX_RATE_MIRROR : IDX_RATE, 8'(c));
      chk(32'(FRONT_CFG_O.rate_code), (c > 10) ? 32'h4 : 32'(c));
    end
    for (int k = 0; k < 4; k++) begin
      rdc(IDX_INT_HIGH_MIRROR + 8'(k), k[0] ? 8'h00 : 8'h55);
      wr(IDX_INT_HIGH + 8'(k), 8'h70 + 8'(k));
      rdc(IDX_INT_HIGH_MIRROR + 8'(k), 8'h70 + 8'(k));
      wr(IDX_INT_HIGH_MIRROR + 8'(k), k[0] ? 8'h00 : 8'h55);
      rdc(IDX_INT_HIGH + 8'(k), k[0] ? 8'h00 : 8'h55);
    end
    wr(IDX_INT_HIGH, 8'h20);
    repeat (20) @(posedge CLK_I);
    rdc(IDX_STATUS, 8'h00);
    conv1();
    rdc(IDX_STATUS, 8'h00);
    conv1();
    chk1(EVENT_O, 1'b0);
    rdc(IDX_STATUS, 8'h40);
    rdc(IDX_STATUS, 8'h00);
    wr(IDX_INT_HIGH, 8'h55);
    wr(IDX_CONFIG, 8'hc0);
    dly <= 8'h28;
    wr(IDX_ONE_SHOT, 8'h00);
    repeat (4) @(posedge CLK_I);
    rdc(IDX_STATUS, 8'h80);
    chk1(EVENT_O, 1'b0);
    repeat (60) @(posedge CLK_I);
    dly <= 8'h02;
    // each event source latches alone and drives the event pin
    for (int k = 0; k < 5; k++) begin
      it <= ti[k];
      et <= te[k];
      flt <= (k == 4);
      conv1();
      conv1();
      chk1(EVENT_O, 1'b1);
      rdc(IDX_STATUS, ex[k]);
      repeat (2) @(posedge CLK_I);
      chk1(EVENT_O, 1'b0);
    end
    flt <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      ic <= (k == 0);
      ec <= (k == 1);
      conv1();
      conv1();
      chk1(CRIT_O, 1'b1);
      rdc(IDX_STATUS, k ? 8'h02 : 8'h01);
      rdc(IDX_STATUS, k ? 8'h02 : 8'h01);
      ic <= 1'b0;
      ec <= 1'b0;
      conv1();
      chk1(CRIT_O, 1'b0);
      rdc(IDX_STATUS, 8'h00);
    end
    // comparator mode with the unmask bit off
    wr(IDX_CONFIG, 8'h60);
    it <= 8'h60;
    conv1();
    conv1();
    chk1(EVENT_O, 1'b1);
    rdc(IDX_STATUS, 8'h40);
    rdc(IDX_STATUS, 8'h40);
    it <= 8'h30;
    conv1();
    chk1(EVENT_O, 1'b0);
    rdc(IDX_STATUS, 8'h00);
    wr(IDX_CONFIG, 8'h00);
    foreach (rc[k]) begin
      wr(IDX_RATE, {4'h0, rc[k]});
      period(n);
      chk(n, pe[k]);
    end
    complete_run();
  end
endmodule
`default_nettype wire
